/* File: src/qem_pkg.sv */
// qem_pkg: types and constants for the qword ecc read-merge-write block
// assumes a single clock domain and a memory port whose read data is marked by rsp valid, at any latency
package qem_pkg;
  localparam int QEM_DATA_W = 64;
  localparam int QEM_CHK_W  = 8;
  localparam int QEM_ADDR_W = 32;
  localparam int QEM_BE_W   = 8;
  localparam logic [QEM_BE_W-1:0] QEM_BE_FULL = 8'hff;
  localparam logic [QEM_CHK_W-1:0] QEM_CHK_RST = 8'h00;

  typedef enum logic [1:0] {
    QEM_ST_IDLE,
    QEM_ST_RDWAIT,
    QEM_ST_RMW_RD,
    QEM_ST_RMW_WR
  } qem_state_t;

  typedef struct packed {
    logic                  valid;
    logic                  write;
    logic [QEM_ADDR_W-1:0] addr;
    logic [QEM_BE_W-1:0]   be;
    logic [QEM_DATA_W-1:0] data;
  } qem_req_t;

  typedef struct packed {
    logic                  valid;
    logic                  write;
    logic [QEM_ADDR_W-1:0] addr;
    logic [QEM_BE_W-1:0]   be;
    logic [QEM_DATA_W-1:0] data;
    logic [QEM_CHK_W-1:0]  chk;
  } qem_mem_req_t;

  typedef struct packed {
    logic                  valid;
    logic [QEM_DATA_W-1:0] data;
    logic [QEM_CHK_W-1:0]  chk;
  } qem_mem_rsp_t;

  typedef struct packed {
    logic                  valid;
    logic [QEM_DATA_W-1:0] data;
    logic                  ce;
    logic                  ue;
  } qem_rsp_t;

  typedef struct packed {
    qem_state_t            st;
    qem_req_t              req;
    qem_mem_req_t          mreq;
    qem_rsp_t              rsp;
    logic                  ce_flag;
    logic                  ue_flag;
  } qem_regs_t;
endpackage : qem_pkg

/* File: src/qem_top.sv */
// qem_top: ecc check-code generation, correction and read-merge-write
// assumes the memory answers each read once with rsp valid, in order
`timescale 1ns/1ps
`default_nettype none

// Operation
// - ecc on or off is picked by an input and when off no code is made or checked.
// - with ecc on every 64-bit qword gets an 8-bit check code stored beside it.
// - with ecc on every memory write is a full qword with a fresh code.
// - with ecc on a narrow write reads the qword, merges bytes, recodes and writes it all back.
// - a single-bit error in the merge read is corrected before merging.
// - reads correct any single-bit error and flag, uncorrected, any double error.
module qem_top
  import qem_pkg::*;
(
  input  wire logic         clock_in,
  input  wire logic         sys_rst_in,
  input  wire logic         ecc_en_in,
  input  wire qem_req_t     req_in,
  output logic              req_ready_out,
  output qem_rsp_t          rsp_out,
  output qem_mem_req_t      mem_req_out,
  input  wire logic         mem_ready_in,
  input  wire qem_mem_rsp_t mem_rsp_in,
  input  wire logic         flag_clr_in,
  output logic              ce_flag_out,
  output logic              ue_flag_out
);

  // data bit to code position; powers of two stay for check bits
  function automatic logic [6:0] bit_pos(
    input int idx
  );
    logic [6:0] pos;
    int         n;
    pos = 7'h00;
    n   = 0;
    for (int p = 3; p < 128; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (n == idx) begin
          pos = 7'(p);
        end
        n++;
      end
    end
    return pos;
  endfunction : bit_pos

  // seven position parities, then parity over all the rest
  function automatic logic [QEM_CHK_W-1:0] gen_chk(
    input logic [QEM_DATA_W-1:0] d
  );
    logic [QEM_CHK_W-1:0] c;
    logic [6:0]           pos;
    c = '0;
    for (int i = 0; i < QEM_DATA_W; i++) begin
      pos = bit_pos(i);
      for (int b = 0; b < 7; b++) begin
        if (pos[b]) begin
          c[b] = c[b] ^ d[i];
        end
      end
    end
    c[7] = ^{d, c[6:0]};
    return c;
  endfunction : gen_chk

  qem_regs_t             r_ff;
  qem_regs_t             nxt_r;
  logic                  mem_acc;
  logic                  take;
  logic                  is_read;
  logic                  is_raw_wr;
  logic                  is_full_wr;
  logic                  is_part_wr;
  logic [QEM_DATA_W-1:0] rd_data;
  logic [QEM_CHK_W-1:0]  rd_chk;
  logic [QEM_CHK_W-1:0]  rd_regen;
  logic [6:0]            rd_syn;
  logic                  rd_par;
  logic [QEM_DATA_W-1:0] cor_data;
  logic                  cor_ce;
  logic                  cor_ue;
  logic                  rd_hit;
  logic                  ce_set;
  logic                  ue_set;
  logic [QEM_DATA_W-1:0] merged;
  logic [QEM_CHK_W-1:0]  wr_chk;
  logic [QEM_CHK_W-1:0]  mg_chk;

  // memory takes the pending request at this edge
  assign mem_acc = r_ff.mreq.valid && mem_ready_in;
  // a new request only when nothing is left waiting on memory
  assign take    = req_in.valid && req_ready_out;

  // request kinds; with ecc off writes go out as given
  assign is_read    = take && !req_in.write;
  assign is_raw_wr  = take && req_in.write && !ecc_en_in;
  assign is_full_wr = take && req_in.write && ecc_en_in &&
                      (req_in.be == QEM_BE_FULL);
  assign is_part_wr = take && req_in.write && ecc_en_in &&
                      (req_in.be != QEM_BE_FULL);

  // read side decode
  assign rd_data  = mem_rsp_in.data;
  assign rd_chk   = mem_rsp_in.chk;
  assign rd_regen = gen_chk(rd_data);
  assign rd_syn   = rd_regen[6:0] ^ rd_chk[6:0];
  // odd parity over all 72 bits means exactly one bit flipped
  assign rd_par   = ^{rd_data, rd_chk};
  assign cor_ce   = rd_par;
  assign cor_ue   = !rd_par && (rd_syn != 7'h00);

  // flip the one data bit the syndrome names
  for (genvar gi = 0; gi < QEM_DATA_W; gi++) begin : g_fix
    localparam logic [6:0] BIT_POS = bit_pos(gi);
    assign cor_data[gi] = rd_data[gi] ^ (rd_par && (rd_syn == BIT_POS));
  end

  // corrected old bytes under the new ones
  for (genvar gb = 0; gb < QEM_BE_W; gb++) begin : g_merge
    assign merged[gb*8 +: 8] = r_ff.req.be[gb] ? r_ff.req.data[gb*8 +: 8]
                                               : cor_data[gb*8 +: 8];
  end

  // flags from a checked read or from the read of a merge
  assign rd_hit = mem_rsp_in.valid && ecc_en_in &&
                  ((r_ff.st == QEM_ST_RDWAIT) || (r_ff.st == QEM_ST_RMW_RD));
  assign ce_set = rd_hit && cor_ce;
  assign ue_set = rd_hit && cor_ue;

  // fresh codes for a direct write and for a merged qword
  assign wr_chk = gen_chk(req_in.data);
  assign mg_chk = gen_chk(merged);

  always_comb begin
    nxt_r = r_ff;
    nxt_r.rsp.valid = 1'b0;
    if (mem_acc) begin
      nxt_r.mreq.valid = 1'b0;
    end
    if (flag_clr_in) begin
      nxt_r.ce_flag = 1'b0;
      nxt_r.ue_flag = 1'b0;
    end
    // set after clear, so an error in the clearing cycle is kept
    if (ce_set) begin
      nxt_r.ce_flag = 1'b1;
    end
    if (ue_set) begin
      nxt_r.ue_flag = 1'b1;
    end
    unique case (r_ff.st)
      QEM_ST_IDLE: begin
        if (take) begin
          nxt_r.req        = req_in;
          nxt_r.mreq.valid = 1'b1;
          nxt_r.mreq.addr  = req_in.addr;
          nxt_r.mreq.data  = req_in.data;
          nxt_r.mreq.be    = req_in.be;
          nxt_r.mreq.chk   = QEM_CHK_RST;
          nxt_r.mreq.write = is_raw_wr || is_full_wr;
        end
        if (is_read) begin
          nxt_r.st = QEM_ST_RDWAIT;
        end
        if (is_full_wr) begin
          nxt_r.mreq.chk = wr_chk;
        end
        if (is_part_wr) begin
          // fetch the whole qword first
          nxt_r.mreq.be = QEM_BE_FULL;
          nxt_r.st      = QEM_ST_RMW_RD;
        end
      end
      QEM_ST_RDWAIT: begin
        if (mem_rsp_in.valid) begin
          nxt_r.rsp.valid = 1'b1;
          nxt_r.st        = QEM_ST_IDLE;
          if (ecc_en_in) begin
            nxt_r.rsp.data = cor_data;
            nxt_r.rsp.ce   = cor_ce;
            nxt_r.rsp.ue   = cor_ue;
          end else begin
            nxt_r.rsp.data = rd_data;
            nxt_r.rsp.ce   = 1'b0;
            nxt_r.rsp.ue   = 1'b0;
          end
        end
      end
      QEM_ST_RMW_RD: begin
        if (mem_rsp_in.valid) begin
          nxt_r.mreq.valid = 1'b1;
          nxt_r.mreq.write = 1'b1;
          nxt_r.mreq.be    = QEM_BE_FULL;
          nxt_r.mreq.data  = merged;
          nxt_r.mreq.chk   = mg_chk;
          nxt_r.st         = QEM_ST_RMW_WR;
        end
      end
      QEM_ST_RMW_WR: begin
        if (mem_acc) begin
          nxt_r.st = QEM_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign req_ready_out = (r_ff.st == QEM_ST_IDLE) &&
                         (!r_ff.mreq.valid || mem_ready_in);
  assign rsp_out       = r_ff.rsp;
  assign mem_req_out   = r_ff.mreq;
  assign ce_flag_out   = r_ff.ce_flag;
  assign ue_flag_out   = r_ff.ue_flag;

endmodule : qem_top
`default_nettype wire

/* File: testbench/qem_mem.sv */
// qem_mem: one-qword memory model, data and check code
// assumes one request at a time; ready toggles every cycle
`timescale 1ns/1ps
`default_nettype none
module qem_mem
  import qem_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire qem_mem_req_t req_in,
  input  wire logic [63:0]  flip_in,
  output logic              rdy_out,
  output qem_mem_rsp_t      rsp_out
);
  logic [71:0] mem_ff;
  logic        pend_ff;
  logic        wr;
  assign wr = req_in.valid && rdy_out && req_in.write;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdy_out <= 1'b0;
      rsp_out <= '0;
      pend_ff <= 1'b0;
    end else begin
      rdy_out <= ~rdy_out;
      pend_ff <= req_in.valid && rdy_out && !req_in.write;
      rsp_out <= {pend_ff,
        pend_ff ? mem_ff ^ {flip_in, 8'h00} : ~rsp_out[71:0]};
      for (int i = 0; i < 8; i++)
        if (wr && req_in.be[i]) mem_ff[8*i+8 +: 8] <= req_in.data[8*i +: 8];
      if (wr) mem_ff[7:0] <= req_in.chk;
    end
  end
endmodule : qem_mem
`default_nettype wire

/* File: testbench/qem_top_assertions.sv */
// qem_chk: port assertions for qem_top
// assumes ecc_en_in is held while an operation runs
`timescale 1ns/1ps
`default_nettype none
module qem_chk
  import qem_pkg::*;
(
  input wire logic         clock_in,
  input wire logic         sys_rst_in,
  input wire logic         ecc_en_in,
  input wire qem_req_t     req_in,
  input wire logic         req_ready_out,
  input wire qem_rsp_t     rsp_out,
  input wire qem_mem_req_t mem_req_out,
  input wire logic         mem_ready_in,
  input wire logic         ce_flag_out,
  input wire logic         ue_flag_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  property p_off; !ecc_en_in && mem_req_out.valid && mem_req_out.write
    |-> mem_req_out.chk == QEM_CHK_RST; endproperty
  a_off: assert property (p_off) else $error("code with ecc off");
  property p_raw; rsp_out.valid && !ecc_en_in
    |-> !rsp_out.ce && !rsp_out.ue; endproperty
  a_raw: assert property (p_raw) else $error("check with ecc off");
  property p_full; ecc_en_in && mem_req_out.valid && mem_req_out.write
    |-> mem_req_out.be == QEM_BE_FULL; endproperty
  a_full: assert property (p_full) else $error("narrow write");
  property p_hold; mem_req_out.valid && !mem_ready_in
    |=> $stable(mem_req_out); endproperty
  a_hold: assert property (p_hold) else $error("request moved");
  property p_rmw; ecc_en_in && req_in.valid && req_ready_out && req_in.write
    && req_in.be != QEM_BE_FULL |=> mem_req_out.valid && !mem_req_out.write;
  endproperty
  a_rmw: assert property (p_rmw) else $error("no merge read");
  property p_two; rsp_out.valid |-> !(rsp_out.ce && rsp_out.ue); endproperty
  a_two: assert property (p_two) else $error("ce and ue");
  property p_ce; rsp_out.valid && rsp_out.ce |-> ##[0:1] ce_flag_out;
  endproperty
  a_ce: assert property (p_ce) else $error("ce flag missing");
  property p_ue; rsp_out.valid && rsp_out.ue |-> ue_flag_out; endproperty
  a_ue: assert property (p_ue) else $error("ue flag missing");
  c_ce: cover property (rsp_out.valid && rsp_out.ce);
  c_ue: cover property (rsp_out.valid && rsp_out.ue);
  c_rmw: cover property (req_in.valid && req_ready_out && req_in.be != 8'hff);
endmodule : qem_chk
`default_nettype wire

/* File: testbench/tb_qem_top.sv */
// tb_qem_top: bench for qem_top against qem_mem
// assumes a single qword address is used throughout
`timescale 1ns/1ps
`default_nettype none
module tb_qem_top;
  import qem_pkg::*;
  localparam logic [63:0] A = 64'h0123_4567_89ab_cdef;
  logic clk = 1'b0, rst = 1'b1, ecc = 1'b1, clr = 1'b0, rdy, mrdy, cef, uef;
  logic [63:0] flip = '0;
  qem_req_t req = '0;
  qem_rsp_t rsp, rd;
  qem_mem_req_t mq;
  qem_mem_rsp_t ms;
  int err_total = 0, tests_run = 0, cyc = 0;
  qem_top dut_u (.clock_in(clk), .sys_rst_in(rst), .ecc_en_in(ecc),
    .req_in(req), .req_ready_out(rdy), .rsp_out(rsp), .mem_req_out(mq),
    .mem_ready_in(mrdy), .mem_rsp_in(ms), .flag_clr_in(clr),
    .ce_flag_out(cef), .ue_flag_out(uef));
  qem_mem mem_u (.clk_in(clk), .rst_in(rst), .req_in(mq), .flip_in(flip),
    .rdy_out(mrdy), .rsp_out(ms));
  always #12.5 clk = ~clk;
  always @(posedge clk) if (++cyc > 3000) begin
    err_total++;
    tally_and_finish();
  end
  task tally_and_finish;
    if (err_total == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task ck(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      $display("wrong value at %0t: %h vs %h", $time, g, e);
      err_total++;
    end
  endtask : ck
  task op(input logic w, input logic [7:0] be, input logic [63:0] d);
    @(posedge clk);
    req <= '{1'b1, w, 32'h0000_0040, be, d};
    do @(posedge clk); while (!rdy);
    req.valid <= 1'b0;
    repeat (40) begin
      @(posedge clk);
      if (w ? rdy : rsp.valid) break;
    end
    rd = rsp;
  endtask : op
  task fl(input logic [1:0] e);
    @(posedge clk) clr <= 1'b1;
    ck(64'({cef, uef}), 64'(e));
    @(posedge clk) clr <= 1'b0;
    @(posedge clk) ck(64'({cef, uef}), 64'h0);
  endtask : fl
  task t_err;
    op(1'b1, 8'hff, A);
    flip <= 64'h0000_0000_0000_0020;
    op(1'b0, 8'hff, '0);
    ck(rd.data, A);
    ck(64'({rd.ce, rd.ue}), 64'h2);
    flip <= 64'h0000_0000_0000_0003;
    fl(2'b10);
    op(1'b0, 8'hff, '0);
    ck(64'({rd.ce, rd.ue}), 64'h1);
    flip <= '0;
    fl(2'b01);
  endtask : t_err
  task t_rmw;
    flip <= 64'h0000_0100_0000_0000;
    op(1'b1, 8'h0f, ~A);
    flip <= '0;
    fl(2'b10);
    op(1'b0, 8'hff, '0);
    ck(rd.data, {A[63:32], ~A[31:0]});
  endtask : t_rmw
  task t_off;
    @(posedge clk) ecc <= 1'b0;
    op(1'b1, 8'h0f, A);
    flip <= 64'h0000_0000_0000_0001;
    op(1'b0, 8'hff, '0);
    flip <= '0;
    ck(rd.data, A ^ 64'h1);
    ck(64'({rd.ce, rd.ue}), 64'h0);
  endtask : t_off
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_err();
    t_rmw();
    t_off();
    tally_and_finish();
  end
endmodule : tb_qem_top
bind qem_top qem_chk chk_u (.clock_in, .sys_rst_in, .ecc_en_in, .req_in,
  .req_ready_out, .rsp_out, .mem_req_out, .mem_ready_in, .ce_flag_out,
  .ue_flag_out);
`default_nettype wire
